// ### core/timer8_waveform_modes.sv
// 8-bit timer/counter with compare channel A and four waveform modes
//
// Overview of operation
// - mode select sets counting; output mode only actions
// - normal mode increments, wraps 0xff to 0x00
// - normal overflow flag set when count becomes zero
// - clear-on-compare clears counter after match A
// - clear-on-compare sets compare flag at TOP
// - clear-on-compare compare writes act immediately
// - clear-on-compare toggle output on each match
// - clear-on-compare overflow flag on MAX wrap
// - timer tick from prescale 1..1024 divider
// - fast PWM TOP is 0xff or compare A
// - fast PWM overflow flag at TOP
// - fast PWM mode two/three set/clear, inverse
// - fast PWM period prescale times TOP+1 (256 at MAX)
// - fast PWM extreme compare values: spike, constant
// - fast PWM toggle mode gives 50% duty
// - phase correct counts up then down
// - phase correct clear up-match, set down-match
// - phase correct holds TOP one tick
// - phase correct overflow flag at BOTTOM
// - phase correct period prescale times 2*TOP (510 at MAX)
// - phase correct extremes give constant levels
// - phase correct forced up-match action at BOTTOM
// - pin driven only when direction is output
// - PWM compare writes buffered until TOP
// - output mode zero leaves output unchanged
`timescale 1ns/1ns
`default_nettype none

module timer8_waveform_modes #(
	parameter int DIV_W = timer8_pkg::DIV_W
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [timer8_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [timer8_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [timer8_pkg::DATA_W-1:0] reg_rdata,
	output logic compare_a_output_o,
	output logic compare_a_output_oe,
	output logic overflow_flag,
	output logic compare_a_flag
);
	if (DIV_W < timer8_pkg::DIV_W) begin : g_div_check
		$error("prescale divider too narrow for divide by 1024");
	end

	timer8_pkg::timer_state_s st_ff;
	timer8_pkg::timer_state_s nxt_st;
	timer8_pkg::reg_req_s req;
	logic tick;
	logic cnt_wr;
	logic [timer8_pkg::CNT_W-1:0] top;
	logic match;
	logic at_top;
	logic at_bottom;
	logic up_phase;

	function automatic logic [timer8_pkg::DIV_W-1:0] div_limit(input logic [2:0] sel);
		case (sel)
			3'h1: div_limit = timer8_pkg::DIV_1;
			3'h2: div_limit = timer8_pkg::DIV_8;
			3'h3: div_limit = timer8_pkg::DIV_32;
			3'h4: div_limit = timer8_pkg::DIV_64;
			3'h5: div_limit = timer8_pkg::DIV_128;
			3'h6: div_limit = timer8_pkg::DIV_256;
			default: div_limit = timer8_pkg::DIV_1024;
		endcase
	endfunction

	function automatic logic is_pwm(input timer8_pkg::waveform_mode_sel_e m);
		is_pwm = (m == timer8_pkg::MODE_PC_MAX) || (m == timer8_pkg::MODE_PC_CMPA) ||
			(m == timer8_pkg::MODE_FAST_MAX) || (m == timer8_pkg::MODE_FAST_CMPA);
	endfunction

	function automatic logic is_pc(input timer8_pkg::waveform_mode_sel_e m);
		is_pc = (m == timer8_pkg::MODE_PC_MAX) || (m == timer8_pkg::MODE_PC_CMPA);
	endfunction

	function automatic logic is_fast(input timer8_pkg::waveform_mode_sel_e m);
		is_fast = (m == timer8_pkg::MODE_FAST_MAX) || (m == timer8_pkg::MODE_FAST_CMPA);
	endfunction

	assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
	assign cnt_wr = req.wr && (req.addr == timer8_pkg::ADDR_COUNT);

	// tick every N system clocks, N from the clock select; select 0 stops
	assign tick = (st_ff.clk_sel != 3'h0) &&
		(st_ff.div[timer8_pkg::DIV_W-1:0] >= div_limit(st_ff.clk_sel));

	// TOP is compare A in modes 2, 5 and 7, else MAX
	assign top = (st_ff.mode == timer8_pkg::MODE_PC_CMPA ||
		st_ff.mode == timer8_pkg::MODE_FAST_CMPA || st_ff.mode == timer8_pkg::MODE_CTC) ?
		st_ff.compare_a_value : timer8_pkg::CNT_MAX;
	assign match = (st_ff.counter_value == st_ff.compare_a_value) && !st_ff.match_block;
	assign at_top = st_ff.counter_value == top;
	assign at_bottom = st_ff.counter_value == timer8_pkg::CNT_BOTTOM;
	// bottom counts as an up-match and top as a down-match so extremes stay flat
	assign up_phase = at_bottom || (!st_ff.count_down && !at_top);

	always_comb begin
		logic up_lvl;
		up_lvl = 1'b0;
		nxt_st = st_ff;
		nxt_st.rdata = '0;
		// up-match level: clear for non-inverted, set for inverted
		up_lvl = (st_ff.com == timer8_pkg::COM_INV);

		// write one to clear, done before the tick so a set in the same cycle wins
		if (req.wr && req.addr == timer8_pkg::ADDR_FLAGS) begin
			if (req.wdata[timer8_pkg::FLAG_OVF_BIT]) begin
				nxt_st.overflow_flag = 1'b0;
			end
			if (req.wdata[timer8_pkg::FLAG_CMPA_BIT]) begin
				nxt_st.compare_a_flag = 1'b0;
			end
		end

		if (st_ff.clk_sel == 3'h0 || tick) begin
			nxt_st.div = '0;
		end else begin
			nxt_st.div = st_ff.div + 1'b1;
		end

		if (tick) begin
			nxt_st.match_block = 1'b0;
			if (match) begin
				nxt_st.compare_a_flag = 1'b1;
			end
			unique case (st_ff.mode)
				timer8_pkg::MODE_CTC: begin
					// clear after match with the live compare value
					// a blocked match must not clear either
					if (match) begin
						nxt_st.counter_value = timer8_pkg::CNT_BOTTOM;
					end else begin
						nxt_st.counter_value = st_ff.counter_value + 1'b1;
					end
					// match at TOP raises the compare flag above
					// overflow only when running past MAX
					if (st_ff.counter_value == timer8_pkg::CNT_MAX) begin
						nxt_st.overflow_flag = 1'b1;
					end
					if (match && st_ff.com == timer8_pkg::COM_TOGGLE) begin
						nxt_st.compare_a_output = !st_ff.compare_a_output;
					end else if (match && st_ff.com == timer8_pkg::COM_NONINV) begin
						nxt_st.compare_a_output = 1'b0;
					end else if (match && st_ff.com == timer8_pkg::COM_INV) begin
						nxt_st.compare_a_output = 1'b1;
					end
				end
				timer8_pkg::MODE_FAST_MAX, timer8_pkg::MODE_FAST_CMPA: begin
					if (at_top) begin
						// clear after TOP, period TOP+1 ticks
						nxt_st.counter_value = timer8_pkg::CNT_BOTTOM;
						nxt_st.overflow_flag = 1'b1;
						nxt_st.compare_a_value = st_ff.compare_a_buf;
					end else begin
						nxt_st.counter_value = st_ff.counter_value + 1'b1;
					end
					// top-to-bottom action wins over a match at MAX
					if (at_top && st_ff.com[1]) begin
						nxt_st.compare_a_output = st_ff.com[0];
					end else if (match && st_ff.com[1]) begin
						nxt_st.compare_a_output = !st_ff.com[0];
					end else if (match && st_ff.com == timer8_pkg::COM_TOGGLE) begin
						nxt_st.compare_a_output = !st_ff.compare_a_output;
					end
				end
				timer8_pkg::MODE_PC_MAX, timer8_pkg::MODE_PC_CMPA: begin
					// TOP shown one tick, then reverse
					if (!st_ff.count_down && at_top) begin
						nxt_st.count_down = 1'b1;
						nxt_st.counter_value = st_ff.counter_value - 1'b1;
						if (st_ff.compare_a_value == timer8_pkg::CNT_MAX &&
							st_ff.compare_a_buf != timer8_pkg::CNT_MAX) begin
							nxt_st.sym_pending = 1'b1;
						end
						nxt_st.compare_a_value = st_ff.compare_a_buf;
					end else if (st_ff.count_down && at_bottom) begin
						nxt_st.count_down = 1'b0;
						nxt_st.counter_value = st_ff.counter_value + 1'b1;
					end else if (st_ff.count_down) begin
						nxt_st.counter_value = st_ff.counter_value - 1'b1;
					end else begin
						nxt_st.counter_value = st_ff.counter_value + 1'b1;
					end
					// overflow when the count lands on BOTTOM
					if (st_ff.count_down && st_ff.counter_value == 8'h01) begin
						nxt_st.overflow_flag = 1'b1;
					end
					if (st_ff.com[1]) begin
						if (at_bottom && st_ff.count_down && st_ff.sym_pending) begin
							// forced up-match action keeps symmetry about BOTTOM
							nxt_st.compare_a_output = up_lvl;
							nxt_st.sym_pending = 1'b0;
						end else if (match) begin
							nxt_st.compare_a_output = up_phase ? up_lvl : !up_lvl;
						end
					end else if (match && st_ff.com == timer8_pkg::COM_TOGGLE) begin
						nxt_st.compare_a_output = !st_ff.compare_a_output;
					end
					if (at_bottom && st_ff.count_down) begin
						nxt_st.sym_pending = 1'b0;
					end
				end
				default: begin
					// normal and the reserved codes 4 and 6 just count up
					nxt_st.counter_value = st_ff.counter_value + 1'b1;
					// overflow when the count becomes zero
					if (st_ff.counter_value == timer8_pkg::CNT_MAX) begin
						nxt_st.overflow_flag = 1'b1;
					end
					if (match && st_ff.com == timer8_pkg::COM_TOGGLE) begin
						nxt_st.compare_a_output = !st_ff.compare_a_output;
					end else if (match && st_ff.com[1]) begin
						nxt_st.compare_a_output = st_ff.com[0];
					end
				end
			endcase
			// output mode zero matches none of the output branches above
		end

		if (req.wr) begin
			unique case (req.addr)
				timer8_pkg::ADDR_CTRL: begin
					// mode and output action are separate fields
					nxt_st.mode = timer8_pkg::waveform_mode_sel_e'(
						req.wdata[timer8_pkg::CTRL_MODE_LSB +: 3]);
					nxt_st.com = timer8_pkg::compare_output_mode_e'(
						req.wdata[timer8_pkg::CTRL_COM_LSB +: 2]);
					nxt_st.clk_sel = req.wdata[timer8_pkg::CTRL_CLK_LSB +: 3];
					nxt_st.ddr = req.wdata[timer8_pkg::CTRL_DDR_BIT];
				end
				timer8_pkg::ADDR_COUNT: begin
					// write beats the tick and blocks the next match
					nxt_st.counter_value = req.wdata[timer8_pkg::CNT_W-1:0];
					nxt_st.match_block = 1'b1;
					if (is_pc(st_ff.mode) &&
						req.wdata[timer8_pkg::CNT_W-1:0] > st_ff.compare_a_value) begin
						nxt_st.sym_pending = 1'b1;
					end
				end
				timer8_pkg::ADDR_CMPA: begin
					nxt_st.compare_a_buf = req.wdata[timer8_pkg::CNT_W-1:0];
					if (!is_pwm(st_ff.mode)) begin
						nxt_st.compare_a_value = req.wdata[timer8_pkg::CNT_W-1:0];
					end
				end
				timer8_pkg::ADDR_FLAGS: begin
					// flags are cleared ahead of the tick logic
				end
				default: begin
				end
			endcase
		end

		if (req.rd) begin
			unique case (req.addr)
				timer8_pkg::ADDR_CTRL: begin
					nxt_st.rdata[timer8_pkg::CTRL_MODE_LSB +: 3] = st_ff.mode;
					nxt_st.rdata[timer8_pkg::CTRL_COM_LSB +: 2] = st_ff.com;
					nxt_st.rdata[timer8_pkg::CTRL_CLK_LSB +: 3] = st_ff.clk_sel;
					nxt_st.rdata[timer8_pkg::CTRL_DDR_BIT] = st_ff.ddr;
				end
				timer8_pkg::ADDR_COUNT: begin
					nxt_st.rdata[timer8_pkg::CNT_W-1:0] = st_ff.counter_value;
				end
				timer8_pkg::ADDR_CMPA: begin
					nxt_st.rdata[timer8_pkg::CNT_W-1:0] = st_ff.compare_a_buf;
				end
				timer8_pkg::ADDR_FLAGS: begin
					nxt_st.rdata[timer8_pkg::FLAG_OVF_BIT] = st_ff.overflow_flag;
					nxt_st.rdata[timer8_pkg::FLAG_CMPA_BIT] = st_ff.compare_a_flag;
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign reg_rdata = st_ff.rdata;
	assign compare_a_output_o = st_ff.compare_a_output;
	// the pin is driven only while its direction bit selects output
	assign compare_a_output_oe = st_ff.ddr;
	assign overflow_flag = st_ff.overflow_flag;
	assign compare_a_flag = st_ff.compare_a_flag;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	sequence s_tick_clean;
		tick && !cnt_wr && !req.wr;
	endsequence

	sequence s_pc_at_top;
		s_tick_clean ##0 is_pc(st_ff.mode) && !st_ff.count_down && at_top;
	endsequence

	a_normal_wrap: assert property (
		s_tick_clean ##0 (st_ff.mode == timer8_pkg::MODE_NORMAL &&
		st_ff.counter_value == timer8_pkg::CNT_MAX)
		|=> st_ff.counter_value == timer8_pkg::CNT_BOTTOM && overflow_flag)
		else $error("normal mode did not wrap with overflow");
	a_ctc_clear: assert property (
		s_tick_clean ##0 (st_ff.mode == timer8_pkg::MODE_CTC && match)
		|=> st_ff.counter_value == timer8_pkg::CNT_BOTTOM && compare_a_flag)
		else $error("clear-on-compare did not clear on match");
	a_pc_top_hold: assert property (
		s_pc_at_top |=> st_ff.count_down &&
		st_ff.counter_value == $past(st_ff.counter_value) - 8'h01)
		else $error("phase correct did not reverse after TOP");
	a_pc_bottom_ovf: assert property (
		s_tick_clean ##0 (is_pc(st_ff.mode) && st_ff.count_down &&
		st_ff.counter_value == 8'h01) |=> overflow_flag && at_bottom)
		else $error("phase correct overflow missing at BOTTOM");
	a_com_zero_hold: assert property (
		st_ff.com == timer8_pkg::COM_NONE && !req.wr |=> $stable(compare_a_output_o))
		else $error("output changed with output mode zero");
	a_write_prio: assert property (
		cnt_wr |=> st_ff.counter_value == $past(req.wdata[timer8_pkg::CNT_W-1:0]) &&
		st_ff.match_block)
		else $error("counter write lost");
	a_normal_count: assert property (
		s_tick_clean ##0 (st_ff.mode == timer8_pkg::MODE_NORMAL &&
		st_ff.counter_value != timer8_pkg::CNT_MAX) |=> st_ff.counter_value == $past(st_ff.counter_value) + 8'h01)
		else $error("normal mode did not increment");
	a_ctc_wrap_ovf: assert property (
		s_tick_clean ##0 (st_ff.mode == timer8_pkg::MODE_CTC &&
		st_ff.counter_value == timer8_pkg::CNT_MAX) |=> overflow_flag)
		else $error("clear-on-compare overflow missing at MAX wrap");
	a_fast_match_set: assert property (
		s_tick_clean ##0 (is_fast(st_ff.mode) && match && !at_top &&
		st_ff.com == timer8_pkg::COM_NONINV) |=> compare_a_output_o)
		else $error("fast PWM match did not set the output");
	a_pc_up_clear: assert property (
		s_tick_clean ##0 (is_pc(st_ff.mode) && match && up_phase &&
		st_ff.com == timer8_pkg::COM_NONINV) |=> !compare_a_output_o)
		else $error("phase correct up-match did not clear the output");
	a_pc_down_set: assert property (
		s_tick_clean ##0 (is_pc(st_ff.mode) && match && !up_phase &&
		st_ff.com == timer8_pkg::COM_NONINV) |=> compare_a_output_o)
		else $error("phase correct down-match did not set the output");
	a_pc_sym_force: assert property (
		s_tick_clean ##0 (is_pc(st_ff.mode) && at_bottom && st_ff.count_down &&
		st_ff.sym_pending && st_ff.com == timer8_pkg::COM_NONINV) |=> !compare_a_output_o)
		else $error("phase correct forced action at BOTTOM missing");
	a_pin_dir: assert property (
		req.wr && req.addr == timer8_pkg::ADDR_CTRL
		|=> compare_a_output_oe == $past(req.wdata[timer8_pkg::CTRL_DDR_BIT]))
		else $error("pin enable does not follow direction bit");
	a_fast_top_clear: assert property (
		s_tick_clean ##0 (is_fast(st_ff.mode) && at_top &&
		st_ff.com == timer8_pkg::COM_NONINV) |=> !compare_a_output_o && overflow_flag)
		else $error("fast PWM top-to-bottom action wrong");
	a_pwm_buffered: assert property (
		req.wr && req.addr == timer8_pkg::ADDR_CMPA && is_pwm(st_ff.mode) && !(tick && at_top)
		|=> st_ff.compare_a_value == $past(st_ff.compare_a_value))
		else $error("PWM compare write was not buffered");
endmodule

`default_nettype wire

// ### include/timer8_pkg.sv
// shared constants and types for the 8-bit waveform timer
package timer8_pkg;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;
	localparam int CNT_W = 8;
	localparam int DIV_W = 10;

	// register offsets
	localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h0;
	localparam logic [ADDR_W-1:0] ADDR_COUNT = 4'h1;
	localparam logic [ADDR_W-1:0] ADDR_CMPA = 4'h2;
	localparam logic [ADDR_W-1:0] ADDR_FLAGS = 4'h3;

	// control and flag register field positions
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_COM_LSB = 4;
	localparam int CTRL_CLK_LSB = 8;
	localparam int CTRL_DDR_BIT = 12;
	localparam int FLAG_OVF_BIT = 0;
	localparam int FLAG_CMPA_BIT = 1;

	localparam logic [CNT_W-1:0] CNT_BOTTOM = 8'h00;
	localparam logic [CNT_W-1:0] CNT_MAX = 8'hff;

	typedef enum logic [2:0] {
		MODE_NORMAL = 3'b000,
		MODE_PC_MAX = 3'b001,
		MODE_CTC = 3'b010,
		MODE_FAST_MAX = 3'b011,
		MODE_RSVD4 = 3'b100,
		MODE_PC_CMPA = 3'b101,
		MODE_RSVD6 = 3'b110,
		MODE_FAST_CMPA = 3'b111
	} waveform_mode_sel_e;

	typedef enum logic [1:0] {
		COM_NONE = 2'b00,
		COM_TOGGLE = 2'b01,
		COM_NONINV = 2'b10,
		COM_INV = 2'b11
	} compare_output_mode_e;

	// prescale divide-minus-one values for clock selects 1..7
	localparam logic [DIV_W-1:0] DIV_1 = 10'h000;
	localparam logic [DIV_W-1:0] DIV_8 = 10'h007;
	localparam logic [DIV_W-1:0] DIV_32 = 10'h01f;
	localparam logic [DIV_W-1:0] DIV_64 = 10'h03f;
	localparam logic [DIV_W-1:0] DIV_128 = 10'h07f;
	localparam logic [DIV_W-1:0] DIV_256 = 10'h0ff;
	localparam logic [DIV_W-1:0] DIV_1024 = 10'h3ff;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} reg_req_s;

	typedef struct packed {
		waveform_mode_sel_e mode;
		compare_output_mode_e com;
		logic [2:0] clk_sel;
		logic ddr;
		logic [CNT_W-1:0] counter_value;
		logic [CNT_W-1:0] compare_a_value;
		logic [CNT_W-1:0] compare_a_buf;
		logic count_down;
		logic overflow_flag;
		logic compare_a_flag;
		logic compare_a_output;
		logic match_block;
		logic sym_pending;
		logic [DIV_W-1:0] div;
		logic [DATA_W-1:0] rdata;
	} timer_state_s;
endpackage

// ### verification/timer8_tb.sv
// self-checking register-level testbench for the 8-bit waveform timer
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin error_cnt++; \
	$display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); end end
module testbench;
	localparam logic [timer8_pkg::ADDR_W-1:0] CTL = timer8_pkg::ADDR_CTRL;
	localparam logic [timer8_pkg::ADDR_W-1:0] CNT = timer8_pkg::ADDR_COUNT;
	localparam logic [timer8_pkg::ADDR_W-1:0] CMP = timer8_pkg::ADDR_CMPA;
	localparam logic [timer8_pkg::ADDR_W-1:0] FLG = timer8_pkg::ADDR_FLAGS;
	logic clk = 1'h0;
	logic rst_n = 1'h0;
	logic [timer8_pkg::ADDR_W-1:0] reg_addr = '0;
	logic [timer8_pkg::DATA_W-1:0] reg_wdata = '0;
	logic reg_wr = 1'h0;
	logic reg_rd = 1'h0;
	logic [timer8_pkg::DATA_W-1:0] reg_rdata;
	logic oc_o;
	logic oc_oe;
	logic ovf;
	logic cmf;
	logic [timer8_pkg::DATA_W-1:0] d;
	int error_cnt = 0;
	int num_checks = 0;
	int n;
	int p;
	int h;
	int dv[7] = '{1, 8, 32, 64, 128, 256, 1024};

	always #4 clk = ~clk;

	timer8_waveform_modes dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.compare_a_output_o(oc_o), .compare_a_output_oe(oc_oe), .overflow_flag(ovf),
		.compare_a_flag(cmf));

	function automatic logic [15:0] ctl(input logic [2:0] m, input logic [1:0] c,
		input logic [2:0] s, input logic e);
		return {3'h0, e, 1'h0, s, 2'h0, c, 1'h0, m};
	endfunction

	// the trailing idle cycle keeps two back-to-back calls from colliding on a strobe
	task automatic wr(input logic [timer8_pkg::ADDR_W-1:0] a, input logic [15:0] v);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'h1;
		@(posedge clk);
		reg_wr <= 1'h0;
		@(posedge clk);
	endtask

	task automatic rd(input logic [timer8_pkg::ADDR_W-1:0] a, output logic [15:0] v);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge clk);
		reg_rd <= 1'h0;
		#1;
		v = reg_rdata;
		@(posedge clk);
	endtask

	function automatic logic sig(input int s);
		case (s)
			0: return ovf;
			1: return cmf;
			default: return oc_o;
		endcase
	endfunction

	// bounded wait; the closing compare flags a hang as a mismatch
	task automatic wt(input int s, input logic v, output int c);
		c = 0;
		while (sig(s) !== v && c < 5000) begin
			@(posedge clk);
			c++;
		end
		`CHK(sig(s), v)
	endtask

	task automatic per(output int c);
		int t;
		wt(2, 1'h0, t);
		wt(2, 1'h1, t);
		wt(2, 1'h0, c);
		wt(2, 1'h1, t);
		c = c + t;
	endtask

	task automatic edges(input int cyc, output int e);
		logic l;
		e = 0;
		l = oc_o;
		repeat (cyc) begin
			@(posedge clk);
			if (oc_o !== l) e++;
			l = oc_o;
		end
	endtask

	// high times of both polarities must add up to one period
	task automatic pwm(input logic [2:0] m, input logic [15:0] cv, input int pe);
		int hs;
		hs = 0;
		wr(CMP, cv);
		for (int c = 2; c < 4; c++) begin
			wr(CTL, ctl(m, 2'(c), 3'h1, 1'h1));
			if (c == 2) repeat (600) @(posedge clk);
			per(p);
			`CHK(p, pe)
			wt(2, 1'h1, n);
			wt(2, 1'h0, h);
			hs += h;
		end
		`CHK(hs, pe)
	endtask

	task automatic done(input string s);
		$display("test %s finished, mismatches so far %0d", s, error_cnt);
	endtask

	task automatic final_report;
		$display("comparisons %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	initial begin
		#560000;
		error_cnt++;
		final_report();
	end

	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1'h1;
		@(posedge clk);
		`CHK({oc_o, oc_oe, ovf, cmf}, 4'h0)
		wr(4'h7, 16'h00aa);
		for (int i = 0; i < 8; i++) begin
			rd(4'(i), d);
			`CHK(d, 16'h0000)
		end
		wr(CMP, 16'h005a);
		rd(CMP, d);
		`CHK(d, 16'h005a)
		done("reset and registers");

		wr(CNT, 16'h00fe);
		wr(CTL, ctl(3'h0, 2'h0, 3'h2, 1'h0));
		wt(0, 1'h1, n);
		rd(CNT, d);
		`CHK(d, 16'h0000)
		wr(FLG, 16'h0003);
		`CHK(ovf, 1'h0)
		wr(CTL, ctl(3'h6, 2'h0, 3'h1, 1'h0));
		wr(CNT, 16'h0020);
		rd(CNT, d);
		`CHK(d, 16'h0021)
		done("normal overflow");

		// compare value below the count: must run through the wrap first
		wr(CTL, ctl(3'h2, 2'h0, 3'h0, 1'h0));
		wr(CNT, 16'h0010);
		wr(CMP, 16'h0003);
		wr(FLG, 16'h0003);
		wr(CTL, ctl(3'h2, 2'h0, 3'h1, 1'h0));
		wt(1, 1'h1, n);
		`CHK(ovf, 1'h1)
		`CHK(n > 235 && n < 256, 1'h1)
		done("clear-on-compare late match");

		wr(CMP, 16'h0001);
		for (int i = 0; i < 7; i++) begin
			wr(CTL, ctl(3'h2, 2'h1, 3'(i + 1), 1'h1));
			per(p);
			`CHK(p, 4 * dv[i])
		end
		`CHK(oc_oe, 1'h1)
		wr(CTL, ctl(3'h2, 2'h0, 3'h1, 1'h0));
		edges(64, n);
		`CHK(n, 0)
		`CHK(oc_oe, 1'h0)
		done("clear-on-compare toggle");

		pwm(3'h3, 16'h0040, 256);
		wr(CMP, 16'h00ff);
		repeat (600) @(posedge clk);
		edges(600, n);
		`CHK(n, 0)
		wr(CMP, 16'h0000);
		repeat (600) @(posedge clk);
		wt(2, 1'h1, n);
		wt(2, 1'h0, h);
		`CHK(h, 1)
		wr(CMP, 16'h0009);
		wr(CTL, ctl(3'h7, 2'h1, 3'h1, 1'h1));
		repeat (600) @(posedge clk);
		per(p);
		`CHK(p, 20)
		wr(FLG, 16'h0003);
		wt(0, 1'h1, n);
		`CHK(n < 16, 1'h1)
		done("fast pwm");

		pwm(3'h1, 16'h0080, 510);
		// last pass leaves compare at max with non-inverted output
		for (int i = 0; i < 4; i++) begin
			wr(CMP, i[1] ? 16'h00ff : 16'h0000);
			wr(CTL, ctl(3'h1, 2'h2 + 2'(i[0] ^ i[1]), 3'h1, 1'h1));
			repeat (1100) @(posedge clk);
			edges(520, n);
			`CHK(n, 0)
			`CHK(oc_o, i[0])
		end
		// leaving max must force the fall at bottom, not at the up match
		wr(CMP, 16'h0080);
		wt(2, 1'h0, n);
		wt(2, 1'h1, h);
		`CHK(h > 300, 1'h1)
		wr(CTL, ctl(3'h1, 2'h2, 3'h2, 1'h1));
		wr(FLG, 16'h0003);
		wt(0, 1'h1, n);
		rd(CNT, d);
		`CHK(d, 16'h0000)
		wr(CMP, 16'h0010);
		wr(CTL, ctl(3'h5, 2'h1, 3'h1, 1'h1));
		repeat (600) @(posedge clk);
		per(p);
		`CHK(p, 64)
		done("phase correct pwm");
		final_report();
	end
endmodule
`default_nettype wire
